// File: step_seq_pkg.sv
/*
 * constants for the internal position step sequencer: register map, option
 * field positions, reset values and dwell timing.
 * assumes a 20 MHz reference clock and a 32-bit apb register bus.
 */
package step_seq_pkg;
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned DWELL_UNIT_MS = 50;
    localparam int unsigned DWELL_UNIT_CYCLES = (CLK_HZ / 1000) * DWELL_UNIT_MS;
    localparam int unsigned START_DELAY_MS = 50;
    localparam int unsigned START_DELAY_CYCLES = (CLK_HZ / 1000) * START_DELAY_MS;

    localparam int STEP_COUNT = 16;
    localparam int STEP_W = 4;
    localparam int PARAM_W = 16;

    // dwell times occupy one word each from offset 0
    localparam logic [7:0] DWELL_BASE_ADDR = 8'h00;
    localparam logic [7:0] SPARE_ADDR = 8'h40;
    localparam logic [7:0] RUN_OPTIONS_ADDR = 8'h44;
    localparam logic [7:0] FIRST_STEP_ADDR = 8'h48;
    localparam logic [7:0] LAST_STEP_ADDR = 8'h4c;
    localparam logic [7:0] STATUS_ADDR = 8'h50;

    // run option digits
    localparam int OPER_LSB = 0;
    localparam int STEP_MODE_LSB = 4;
    localparam int INPUT_MODE_LSB = 8;
    localparam int PROG_MODE_LSB = 12;
    localparam int DIGIT_W = 4;

    localparam logic [PARAM_W-1:0] DWELL_RESET = 16'h0000;
    localparam logic [PARAM_W-1:0] RUN_OPTIONS_RESET = 16'h0000;
    localparam logic [STEP_W-1:0] FIRST_STEP_RESET = 4'h0;
    localparam logic [STEP_W-1:0] LAST_STEP_RESET = 4'hf;

    // status word layout
    localparam int ST_STEP_LSB = 0;
    localparam int ST_RUN_BIT = 4;
    localparam int ST_DWELL_BIT = 5;
    localparam int ST_DONE_BIT = 6;
    localparam int ST_SEARCH_BIT = 7;
endpackage

// File: step_seq.sv
/*
 * internal position step sequencer with apb register access.
 * assumes synchronous inputs from the host's digital command pins, a motion
 * engine that pulses i_motion_done when a step's move completes, and a
 * single 20 MHz clock with asynchronous active-low reset.
 */
// Implementation choices: the register offsets and the APB slave port.
//
// Behaviour
// - each of sixteen steps dwells its own setting times 50 ms after motion
// - options 0 cyclic, 1 single; positive limit starts, negative limit searches
// - options 2 cyclic, 3 single; negative limit starts, positive limit searches
// - step mode 0: timed advance, no start signal, starts after servo-on delay
// - step mode 1: step-change input advances, no start, pulses never halted by it
// - step mode 2: timed advance, start needed, drop halts, reset returns to start
// - step mode 3: input advance, start needed, drop halts, reset returns to start
// - step-change input is level sensitive for setting 0, edge sensitive for 1
// - programme runs from selectable first step through selectable last step
`timescale 1ns/1ps
module step_seq #(
    parameter int unsigned DWELL_UNIT_CYCLES = step_seq_pkg::DWELL_UNIT_CYCLES,
    parameter int unsigned START_DELAY_CYCLES = step_seq_pkg::START_DELAY_CYCLES
) (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_servo_on,
    input wire logic i_positive_limit_input,
    input wire logic i_negative_limit_input,
    input wire logic i_step_change_input,
    input wire logic i_seq_reset,
    input wire logic i_motion_done,
    output logic [3:0] o_step_index,
    output logic o_step_launch,
    output logic o_pulse_enable,
    output logic o_ref_search
);
    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_START_WAIT = 6'b000010,
        ST_MOVE = 6'b000100,
        ST_DWELL = 6'b001000,
        ST_STEP_WAIT = 6'b010000,
        ST_DONE = 6'b100000
    } seq_state_e;

    seq_state_e state_q;
    logic [15:0] dwell_q [16];
    logic [15:0] options_q;
    logic [3:0] first_q;
    logic [3:0] last_q;
    logic [3:0] step_q;
    logic [15:0] units_left_q;
    logic [31:0] tick_cnt_q;
    logic step_in_prev_q;
    logic launch_q;
    logic pulse_en_q;
    logic search_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;

    logic [3:0] oper;
    logic [3:0] step_mode;
    logic [3:0] input_mode;
    logic cyclic;
    logic start_sig;
    logic search_sig;
    logic need_start;
    logic input_advance;
    logic step_event;
    logic run_ok;
    logic wr_en;
    logic dwell_sel;
    logic [31:0] status_word;
    logic unit_tick;
    logic start_tick;
    logic [3:0] next_step;

    assign oper = options_q[step_seq_pkg::OPER_LSB +: step_seq_pkg::DIGIT_W];
    assign step_mode = options_q[step_seq_pkg::STEP_MODE_LSB +: step_seq_pkg::DIGIT_W];
    assign input_mode = options_q[step_seq_pkg::INPUT_MODE_LSB +: step_seq_pkg::DIGIT_W];
    // options above 3 fall back to the behaviour that their low bits select
    assign cyclic = ~oper[0];
    assign start_sig = oper[1] ? i_negative_limit_input : i_positive_limit_input;
    assign search_sig = oper[1] ? i_positive_limit_input : i_negative_limit_input;
    assign need_start = step_mode[1];
    assign input_advance = step_mode[0];
    assign step_event = input_mode[0] ? (i_step_change_input & ~step_in_prev_q) : i_step_change_input;
    assign run_ok = i_servo_on & (~need_start | start_sig) & ~(need_start & i_seq_reset);
    assign unit_tick = tick_cnt_q == DWELL_UNIT_CYCLES - 1;
    assign start_tick = tick_cnt_q == START_DELAY_CYCLES - 1;
    assign next_step = (step_q == last_q) ? first_q : step_q + 4'h1;

    assign wr_en = i_psel & i_penable & pready_q & i_pwrite;
    assign dwell_sel = i_paddr[7:6] == 2'b00 && i_paddr[1:0] == 2'b00;

    assign status_word = {24'h000000,
        search_q,
        state_q == ST_DONE,
        state_q == ST_DWELL,
        pulse_en_q,
        step_q};

    // APB: setup cycle prepares the answer so the access phase completes at once
    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            prdata_q <= 32'h00000000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q <= i_psel & ~i_penable;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
            if (i_psel && !i_penable)
            begin
                if (dwell_sel)
                begin
                    prdata_q <= {16'h0000, dwell_q[i_paddr[5:2]]};
                end
                else if (i_paddr == step_seq_pkg::RUN_OPTIONS_ADDR)
                begin
                    prdata_q <= {16'h0000, options_q};
                end
                else if (i_paddr == step_seq_pkg::FIRST_STEP_ADDR)
                begin
                    prdata_q <= {28'h0000000, first_q};
                end
                else if (i_paddr == step_seq_pkg::LAST_STEP_ADDR)
                begin
                    prdata_q <= {28'h0000000, last_q};
                end
                else if (i_paddr == step_seq_pkg::STATUS_ADDR)
                begin
                    prdata_q <= status_word;
                end
                else if (i_paddr != step_seq_pkg::SPARE_ADDR)
                begin
                    pslverr_q <= 1'b1;
                end
            end
        end
    end

    for (genvar g = 0; g < step_seq_pkg::STEP_COUNT; g++)
    begin : g_dwell
        always_ff @(posedge i_ref_clk or negedge i_reset_n)
        begin
            if (!i_reset_n)
            begin
                dwell_q[g] <= step_seq_pkg::DWELL_RESET;
            end
            else if (wr_en && dwell_sel && i_paddr[5:2] == 4'(g))
            begin
                dwell_q[g] <= i_pwdata[15:0];
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            options_q <= step_seq_pkg::RUN_OPTIONS_RESET;
            first_q <= step_seq_pkg::FIRST_STEP_RESET;
            last_q <= step_seq_pkg::LAST_STEP_RESET;
        end
        else if (wr_en)
        begin
            if (i_paddr == step_seq_pkg::RUN_OPTIONS_ADDR)
            begin
                options_q <= i_pwdata[15:0];
            end
            if (i_paddr == step_seq_pkg::FIRST_STEP_ADDR)
            begin
                first_q <= i_pwdata[3:0];
            end
            if (i_paddr == step_seq_pkg::LAST_STEP_ADDR)
            begin
                last_q <= i_pwdata[3:0];
            end
        end
    end

    // shared cycle counter for the start delay and the dwell unit
    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            tick_cnt_q <= 32'h00000000;
        end
        else if ((state_q == ST_START_WAIT && !start_tick) || (state_q == ST_DWELL && !unit_tick))
        begin
            tick_cnt_q <= tick_cnt_q + 32'h00000001;
        end
        else
        begin
            tick_cnt_q <= 32'h00000000;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            step_in_prev_q <= 1'b0;
            search_q <= 1'b0;
        end
        else
        begin
            step_in_prev_q <= i_step_change_input;
            // search only commanded while the programme is not moving
            search_q <= search_sig & i_servo_on & (state_q != ST_MOVE);
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state_q <= ST_IDLE;
            step_q <= step_seq_pkg::FIRST_STEP_RESET;
            units_left_q <= 16'h0000;
            launch_q <= 1'b0;
            pulse_en_q <= 1'b0;
        end
        else
        begin
            launch_q <= 1'b0;
            if (!run_ok)
            begin
                // servo off, dropped start or reset: pulses stop this edge
                state_q <= ST_IDLE;
                pulse_en_q <= 1'b0;
                step_q <= first_q;
            end
            else
            begin
                unique case (state_q)
                    ST_IDLE:
                    begin
                        step_q <= first_q;
                        state_q <= ST_START_WAIT;
                    end
                    ST_START_WAIT:
                    begin
                        if (start_tick)
                        begin
                            state_q <= ST_MOVE;
                            launch_q <= 1'b1;
                            pulse_en_q <= 1'b1;
                        end
                    end
                    ST_MOVE:
                    begin
                        // step-change input is ignored here, so motion is never cut by it
                        if (i_motion_done)
                        begin
                            pulse_en_q <= 1'b0;
                            units_left_q <= dwell_q[step_q];
                            state_q <= ST_DWELL;
                        end
                    end
                    ST_DWELL:
                    begin
                        if (units_left_q == 16'h0000)
                        begin
                            if (input_advance)
                            begin
                                state_q <= ST_STEP_WAIT;
                            end
                            else if (step_q == last_q && !cyclic)
                            begin
                                state_q <= ST_DONE;
                            end
                            else
                            begin
                                step_q <= next_step;
                                state_q <= ST_MOVE;
                                launch_q <= 1'b1;
                                pulse_en_q <= 1'b1;
                            end
                        end
                        else if (unit_tick)
                        begin
                            units_left_q <= units_left_q - 16'h0001;
                        end
                    end
                    ST_STEP_WAIT:
                    begin
                        if (step_q == last_q && !cyclic)
                        begin
                            state_q <= ST_DONE;
                        end
                        else if (step_event)
                        begin
                            step_q <= next_step;
                            state_q <= ST_MOVE;
                            launch_q <= 1'b1;
                            pulse_en_q <= 1'b1;
                        end
                    end
                    ST_DONE:
                    begin
                        state_q <= ST_DONE;
                    end
                endcase
            end
        end
    end

    assign o_prdata = prdata_q;
    assign o_pready = pready_q;
    assign o_pslverr = pslverr_q;
    assign o_step_index = step_q;
    assign o_step_launch = launch_q;
    assign o_pulse_enable = pulse_en_q;
    assign o_ref_search = search_q;
endmodule

// File: step_seq_chk.sv
/* port assertions for the step sequencer.
   assumes it is bound to every step_seq instance. */
`timescale 1ns/1ps
module step_seq_chk (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic i_servo_on,
    input wire logic i_positive_limit_input,
    input wire logic i_negative_limit_input,
    input wire logic i_step_change_input,
    input wire logic i_seq_reset,
    input wire logic i_motion_done,
    input wire logic [3:0] o_step_index,
    input wire logic o_step_launch,
    input wire logic o_pulse_enable,
    input wire logic o_ref_search
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_reset_n);
    sequence setup_s;
        i_psel && !i_penable;
    endsequence
    sequence move_end_s;
        o_pulse_enable && i_motion_done;
    endsequence
    ready_after_setup_a: assert property (setup_s |=> o_pready) else $error("ready missing after setup");
    ready_needs_setup_a: assert property (o_pready |-> $past(i_psel && !i_penable))
        else $error("ready without setup");
    error_with_ready_a: assert property (o_pslverr |-> o_pready) else $error("error outside access");
    launch_single_a: assert property (o_step_launch |=> !o_step_launch) else $error("launch too long");
    launch_moves_a: assert property (o_step_launch |-> o_pulse_enable) else $error("launch without pulses");
    move_ends_a: assert property (move_end_s |=> !o_pulse_enable) else $error("pulses after move end");
    servo_off_halts_a: assert property (!i_servo_on |=> !o_pulse_enable && !o_step_launch)
        else $error("pulses without servo on");
    step_held_a: assert property (o_pulse_enable && !o_step_launch |-> $stable(o_step_index))
        else $error("step changed during move");
    search_cause_a: assert property (o_ref_search |-> $past(i_servo_on && (i_positive_limit_input
        || i_negative_limit_input))) else $error("search without cause");
endmodule
bind step_seq step_seq_chk chk (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_servo_on(i_servo_on),
    .i_positive_limit_input(i_positive_limit_input), .i_negative_limit_input(i_negative_limit_input),
    .i_step_change_input(i_step_change_input), .i_seq_reset(i_seq_reset), .i_motion_done(i_motion_done),
    .o_step_index(o_step_index), .o_step_launch(o_step_launch), .o_pulse_enable(o_pulse_enable),
    .o_ref_search(o_ref_search));

// File: host_model.sv
/* host controller and motion engine model: registers command pins, ends each move.
   assumes the bench sets i_cmd just after a rising edge. */
`timescale 1ns/1ps
module host_model #(
    parameter int MOVE_CYCLES = 4
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [4:0] i_cmd,
    input wire logic i_launch,
    output logic o_servo_on,
    output logic o_pos,
    output logic o_neg,
    output logic o_step,
    output logic o_reset,
    output logic o_done
);
    int cnt_q;
    // pins change only after an edge, like a real host output stage
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            {o_reset, o_step, o_neg, o_pos, o_servo_on} <= 5'h00;
        else
            {o_reset, o_step, o_neg, o_pos, o_servo_on} <= i_cmd;
    end
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            cnt_q <= 0;
            o_done <= 1'b0;
        end
        else
        begin
            cnt_q <= i_launch ? MOVE_CYCLES : (cnt_q > 0 ? cnt_q - 1 : 0);
            o_done <= (cnt_q == 1);
        end
    end
endmodule

// File: step_seq_tb.sv
/* step sequencer testbench: register checks over apb and programme runs.
   assumes host_model drives command pins and move completion. */
`timescale 1ns/1ps
module step_seq_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [4:0] cmd = 5'h00;
    logic [31:0] prdata;
    logic [3:0] step;
    logic pready, pslverr, servo, pos, neg, stepc, sreset, mdone, launch, pulse, search;
    int miscompares = 0;
    int cmp_count = 0;
    always #25 clk = ~clk;
    step_seq #(.DWELL_UNIT_CYCLES(10), .START_DELAY_CYCLES(5)) dut (.i_ref_clk(clk), .i_reset_n(rst_n),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_servo_on(servo),
        .i_positive_limit_input(pos), .i_negative_limit_input(neg), .i_step_change_input(stepc),
        .i_seq_reset(sreset), .i_motion_done(mdone), .o_step_index(step), .o_step_launch(launch),
        .o_pulse_enable(pulse), .o_ref_search(search));
    host_model host (.i_clk(clk), .i_reset_n(rst_n), .i_cmd(cmd), .i_launch(launch), .o_servo_on(servo),
        .o_pos(pos), .o_neg(neg), .o_step(stepc), .o_reset(sreset), .o_done(mdone));
    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp,
        input logic [31:0] mask, input logic err);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // ready, read data and error are all taken at the rising edge that ends the access
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        psel <= 1'b0;
        penable <= 1'b0;
        chk({31'h0, pready}, 32'h1);
        if (pready !== 1'b1)
            results();
        if (!wr)
            chk(prdata & mask, exp);
        chk({31'h0, pslverr}, {31'h0, err});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
    endtask
    task automatic setc(input logic [4:0] v);
        @(posedge clk);
        cmd <= v;
    endtask
    // waits for the next launch and checks its step and spacing
    task automatic wl(input logic [3:0] s, input int lo, input int hi);
        int n;
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (launch !== 1'b1 && n < hi + 40);
        chk({31'h0, launch}, 32'h1);
        if (launch !== 1'b1)
            results();
        chk({28'h0, step}, {28'h0, s});
        chk({31'h0, pulse}, 32'h1);
        chk({31'h0, n >= lo && n <= hi}, 32'h1);
    endtask
    task automatic nl(input int n);
        repeat (n)
        begin
            @(negedge clk);
            if (launch === 1'b1)
                chk(32'h1, 32'h0);
        end
    endtask
    task automatic halted(input logic [3:0] s);
        repeat (3) @(negedge clk);
        chk({27'h0, pulse, step}, {28'h0, s});
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, 8'h48, 32'h0, 32'h0, 32'hffffffff, 1'b0);
        apb(1'b0, 8'h4c, 32'h0, 32'hf, 32'hffffffff, 1'b0);
        apb(1'b0, 8'h40, 32'h0, 32'h0, 32'hffffffff, 1'b0);
        apb(1'b0, 8'h60, 32'h0, 32'h0, 32'hffffffff, 1'b1);
        wr(8'h3c, 32'h1234);
        apb(1'b0, 8'h3c, 32'h0, 32'h1234, 32'hffffffff, 1'b0);
        $display("test registers done");
        wr(8'h48, 32'h2);
        wr(8'h4c, 32'h3);
        wr(8'h08, 32'h1);
        wr(8'h0c, 32'h0);
        setc(5'h01);
        wl(4'h2, 5, 15);
        wl(4'h3, 14, 24);
        wl(4'h2, 4, 12);
        setc(5'h00);
        halted(4'h2);
        wr(8'h44, 32'h1);
        setc(5'h03);
        wl(4'h2, 5, 15);
        wl(4'h3, 14, 24);
        nl(40);
        apb(1'b0, 8'h50, 32'h0, 32'h40, 32'h40, 1'b0);
        $display("test timed runs done");
        setc(5'h00);
        wr(8'h44, 32'h22);
        setc(5'h01);
        nl(30);
        setc(5'h05);
        wl(4'h2, 5, 15);
        setc(5'h01);
        halted(4'h2);
        setc(5'h05);
        wl(4'h2, 5, 15);
        wl(4'h3, 14, 24);
        setc(5'h15);
        halted(4'h2);
        setc(5'h03);
        repeat (3) @(negedge clk);
        chk({31'h0, search}, 32'h1);
        $display("test start signal done");
        setc(5'h00);
        wr(8'h44, 32'h10);
        setc(5'h01);
        wl(4'h2, 5, 15);
        nl(40);
        setc(5'h09);
        wl(4'h3, 1, 15);
        setc(5'h01);
        repeat (2) @(negedge clk);
        chk({31'h0, pulse}, 32'h1);
        setc(5'h09);
        wl(4'h2, 1, 20);
        setc(5'h00);
        wr(8'h44, 32'h130);
        setc(5'h0b);
        wl(4'h2, 5, 15);
        nl(40);
        setc(5'h03);
        setc(5'h0b);
        wl(4'h3, 1, 15);
        $display("test step input done");
        setc(5'h00);
        wr(8'h44, 32'h21);
        setc(5'h05);
        nl(20);
        chk({31'h0, search}, 32'h1);
        setc(5'h03);
        wl(4'h2, 5, 15);
        setc(5'h00);
        wr(8'h44, 32'h23);
        setc(5'h05);
        wl(4'h2, 5, 15);
        wl(4'h3, 14, 24);
        nl(40);
        $display("test option digits done");
        results();
    end
endmodule
